// ===== core/p2c_channel.v
// Purpose: aux serial channel controller, device side, register port
// Assumes: peripheral generates the line clock; lines are open drain
// Notes:   line clock is sampled by core_clk after two flops
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/100ps
`include "p2c_defines.vh"

module p2c_channel (
    // Clock, reset, enable
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       clk_en,
    // Register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Clock line
    input  wire       aux_clock_line_i,
    output wire       aux_clock_line_o,
    output reg        aux_clock_line_oe_n,
    // Data line
    input  wire       aux_data_line_i,
    output wire       aux_data_line_o,
    output reg        aux_data_line_oe_n,
    // Interrupt requests
    output wire       tx_idle_irq,
    output wire       rx_ready_irq
);

    localparam [6:0] S_OFF     = 7'h01;
    localparam [6:0] S_RX      = 7'h02;
    localparam [6:0] S_RXHOLD  = 7'h04;
    localparam [6:0] S_TXWAIT  = 7'h08;
    localparam [6:0] S_TXLNCH  = 7'h10;
    localparam [6:0] S_TXBITS  = 7'h20;
    localparam [6:0] S_TXTAIL  = 7'h40;

    // Least times round up; each sits below its documented maximum
    localparam integer T4_CYC  = `P2C_CEIL_CYC(`P2C_T4_MIN_NS);
    localparam integer T5_CYC  = `P2C_CEIL_CYC(`P2C_T5_MIN_NS);
    localparam integer T12_CYC = `P2C_CEIL_CYC(`P2C_T12_MIN_NS);
    localparam [9:0] T4_HIT  = T4_CYC[9:0] - `P2C_CNT_ONE;
    localparam [9:0] T5_HIT  = T5_CYC[9:0] - `P2C_CNT_ONE;
    localparam [9:0] T12_HIT = T12_CYC[9:0] - `P2C_CNT_ONE;

    function odd_par;
        input [7:0] d;
        begin
            odd_par = ~(^d);
        end
    endfunction

    wire [1:0]  line_s;
    wire        clk_s;
    wire        dat_s;
    wire        fall;
    wire        rise;
    wire        wr_ctrl;
    wire        wr_tx;
    wire        rd_rx;
    wire [10:0] rx_frame;

    reg         clk_prev_q;
    reg  [6:0]  state_q;
    reg         en_q;
    reg         dir_q;
    reg         idle_q;
    reg         rdy_q;
    reg         perr_q;
    reg         ferr_q;
    reg  [7:0]  rx_byte_q;
    reg  [9:0]  tx_shift_q;
    reg  [10:0] rx_shift_q;
    reg  [3:0]  fall_cnt_q;
    reg  [9:0]  cnt_q;
    reg         tail_run_q;
    reg  [7:0]  rd_mux;

    p2c_sync u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_i  ({aux_clock_line_i, aux_data_line_i}),
        .sync_o   (line_s)
    );

    assign clk_s    = line_s[1];
    assign dat_s    = line_s[0];
    assign fall     = clk_prev_q & ~clk_s;
    assign rise     = ~clk_prev_q & clk_s;
    assign wr_ctrl  = reg_wr && (reg_addr == `P2C_ADDR_CTRL);
    assign wr_tx    = reg_wr && (reg_addr == `P2C_ADDR_TXDATA);
    assign rd_rx    = reg_rd && (reg_addr == `P2C_ADDR_RXDATA);
    assign rx_frame = {dat_s, rx_shift_q[10:1]};

    // Open drain: the only level ever driven is low
    assign aux_clock_line_o = `P2C_LINE_LOW;
    assign aux_data_line_o  = `P2C_LINE_LOW;
    assign tx_idle_irq      = idle_q; // RL13
    assign rx_ready_irq     = rdy_q; // RL19

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_q <= `P2C_LINE_HIGH;
        end else if (clk_en) begin
            clk_prev_q <= clk_s;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q             <= S_OFF;
            en_q                <= `P2C_RST_EN;
            dir_q               <= `P2C_RST_DIR;
            idle_q              <= `P2C_RST_IDLE;
            rdy_q               <= `P2C_RST_FLAG;
            perr_q              <= `P2C_RST_FLAG;
            ferr_q              <= `P2C_RST_FLAG;
            rx_byte_q           <= `P2C_RST_BYTE;
            tx_shift_q          <= {`P2C_RST_BYTE, 2'h0};
            rx_shift_q          <= {`P2C_RST_BYTE, 3'h0};
            fall_cnt_q          <= `P2C_FALL_ZERO;
            cnt_q               <= `P2C_CNT_ZERO;
            tail_run_q          <= 1'b0;
            aux_clock_line_oe_n <= `P2C_OE_ON;
            aux_data_line_oe_n  <= `P2C_OE_OFF;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                en_q  <= reg_wdata[`P2C_CTRL_EN_BIT];
                dir_q <= reg_wdata[`P2C_CTRL_DIR_BIT];
            end
            if (rd_rx) begin
                rdy_q  <= `P2C_RST_FLAG; // RL16
                perr_q <= `P2C_RST_FLAG;
                ferr_q <= `P2C_RST_FLAG;
            end
            if (!en_q) begin
                state_q             <= S_OFF;
                aux_clock_line_oe_n <= `P2C_OE_ON; // RL18
                aux_data_line_oe_n  <= `P2C_OE_OFF; // RL18
            end else begin
                case (state_q)
                    S_OFF: begin
                        fall_cnt_q <= `P2C_FALL_ZERO;
                        if (dir_q) begin
                            state_q <= S_TXWAIT;
                        end else begin
                            state_q             <= S_RX;
                            aux_clock_line_oe_n <= `P2C_OE_OFF; // RL1
                            aux_data_line_oe_n  <= `P2C_OE_OFF; // RL1
                        end
                    end
                    S_RX: begin
                        if (dir_q) begin
                            state_q             <= S_TXWAIT;
                            aux_clock_line_oe_n <= `P2C_OE_ON; // RL2
                            fall_cnt_q          <= `P2C_FALL_ZERO;
                        end else if (fall) begin
                            rx_shift_q <= rx_frame; // RL14
                            fall_cnt_q <= fall_cnt_q + `P2C_FALL_ONE;
                            if (fall_cnt_q == `P2C_LAST_FALL) begin
                                // Whole frame in: start, data, parity, stop
                                rx_byte_q <= rx_frame[8:1]; // RL20
                                rdy_q     <= 1'b1; // RL15
                                perr_q    <= odd_par(rx_frame[8:1]) !=
                                             rx_frame[9];
                                ferr_q    <= rx_frame[0] | ~rx_frame[10];
                                fall_cnt_q          <= `P2C_FALL_ZERO;
                                state_q             <= S_RXHOLD;
                                aux_clock_line_oe_n <= `P2C_OE_ON; // RL17
                            end
                        end
                    end
                    S_RXHOLD: begin
                        // Holding the clock stops a second frame overrunning
                        if (dir_q) begin
                            state_q <= S_TXWAIT;
                        end else if (rd_rx) begin
                            state_q             <= S_RX;
                            aux_clock_line_oe_n <= `P2C_OE_OFF; // RL17
                        end
                    end
                    S_TXWAIT: begin
                        aux_clock_line_oe_n <= `P2C_OE_ON; // RL2
                        if (!dir_q) begin
                            state_q             <= S_RX;
                            aux_clock_line_oe_n <= `P2C_OE_OFF;
                            aux_data_line_oe_n  <= `P2C_OE_OFF;
                        end else if (wr_tx) begin
                            tx_shift_q <= {1'b1, odd_par(reg_wdata),
                                           reg_wdata}; // RL20
                            cnt_q      <= `P2C_CNT_ZERO;
                            state_q    <= S_TXLNCH;
                        end
                    end
                    S_TXLNCH: begin
                        cnt_q <= cnt_q + `P2C_CNT_ONE;
                        if (!dir_q) begin
                            state_q             <= S_RX;
                            aux_clock_line_oe_n <= `P2C_OE_OFF;
                            aux_data_line_oe_n  <= `P2C_OE_OFF;
                        end else begin
                            if (cnt_q == T4_HIT) begin
                                aux_data_line_oe_n <= `P2C_OE_ON; // RL3
                            end
                            if (cnt_q == T5_HIT) begin
                                aux_clock_line_oe_n <= `P2C_OE_OFF; // RL4
                                idle_q              <= 1'b0; // RL5
                                fall_cnt_q          <= `P2C_FALL_ZERO;
                                state_q             <= S_TXBITS;
                            end
                        end
                    end
                    S_TXBITS: begin
                        if (!dir_q) begin
                            state_q            <= S_RX;
                            aux_data_line_oe_n <= `P2C_OE_OFF;
                            idle_q             <= 1'b1;
                        end else if (fall) begin
                            fall_cnt_q <= fall_cnt_q + `P2C_FALL_ONE;
                            if (fall_cnt_q == `P2C_LAST_FALL) begin
                                tail_run_q <= 1'b0;
                                state_q    <= S_TXTAIL;
                            end else begin
                                // A one releases the line, a zero pulls it
                                aux_data_line_oe_n <= tx_shift_q[0]; // RL9
                                tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                            end
                        end
                    end
                    S_TXTAIL: begin
                        if (!tail_run_q) begin
                            cnt_q <= `P2C_CNT_ZERO;
                            if (rise) begin
                                tail_run_q <= 1'b1;
                            end
                        end else if (cnt_q == T12_HIT) begin
                            dir_q              <= 1'b0; // RL10
                            idle_q             <= 1'b1; // RL11
                            aux_data_line_oe_n <= `P2C_OE_OFF; // RL12
                            fall_cnt_q         <= `P2C_FALL_ZERO;
                            state_q            <= S_RX;
                        end else begin
                            cnt_q <= cnt_q + `P2C_CNT_ONE;
                        end
                    end
                    default: begin
                        state_q <= S_OFF;
                    end
                endcase
            end
        end
    end

    always @* begin
        rd_mux = `P2C_RST_BYTE;
        case (reg_addr)
            `P2C_ADDR_CTRL: begin
                rd_mux[`P2C_CTRL_EN_BIT]  = en_q;
                rd_mux[`P2C_CTRL_DIR_BIT] = dir_q;
            end
            `P2C_ADDR_STATUS: begin
                rd_mux[`P2C_STAT_IDLE_BIT] = idle_q;
                rd_mux[`P2C_STAT_RDY_BIT]  = rdy_q;
                rd_mux[`P2C_STAT_PERR_BIT] = perr_q;
                rd_mux[`P2C_STAT_FERR_BIT] = ferr_q;
            end
            `P2C_ADDR_TXDATA: begin
                rd_mux = tx_shift_q[7:0];
            end
            `P2C_ADDR_RXDATA: begin
                rd_mux = rx_byte_q;
            end
            default: begin
                rd_mux = `P2C_RST_BYTE;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `P2C_RST_BYTE;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : `P2C_RST_BYTE;
        end
    end

endmodule

// ===== core/p2c_defines.vh
// Contract
// [RL1] Enabled in receive direction: float clock and data within 1000 ns.
// [RL2] Direction set to transmit: pull clock low to inhibit the peripheral.
// [RL3] After transmit register write: drive data low 45 to 90 ns later.
// [RL4] After transmit register write: release clock 90 to 130 ns later.
// [RL5] Clear transmit idle flag within 1.7 after clock release.
// [RL6] Peripheral latches start bit and clocks 0.002 to 25.003 ms later.
// [RL7] Peripheral clock period 60 to 302 us, high 30 to 151 us.
// [RL8] Start bit fall to parity bit fall lasts at most 2.002 ms.
// [RL9] Transmit: present each bit within 1 us after falling clock edge.
// [RL10] Clear direction 3.5 to 7.1 us after rise following eleventh fall.
// [RL11] Set transmit idle flag within 500 ns of direction clearing.
// [RL12] Direction low after transmit: release data line.
// [RL13] Transmit idle flag set raises an interrupt request.
// [RL14] Receive: sample data on falling clock; peripheral holds it 1/2 us.
// [RL15] Set receive ready within 1.6 us after eleventh falling edge.
// [RL16] Receive register read clears receive ready within 500 ns.
// [RL17] Hold clock low after received frame until receive register read.
// [RL18] Channel disabled: clock driven low, data line released.
// [RL19] Receive ready flag set raises an interrupt request.
// [RL20] Frame: low start, eight data bits LSB first, odd parity, high stop.
//
// Purpose: constants of the aux serial channel controller
// Assumes: 125 MHz core clock, 4-bit register address, 8-bit data
// Notes:   cycle counts are derived in p2c_channel from the times here
`ifndef P2C_DEFINES_VH
`define P2C_DEFINES_VH

`define P2C_ADDR_CTRL       4'h0
`define P2C_ADDR_STATUS     4'h4
`define P2C_ADDR_TXDATA     4'h8
`define P2C_ADDR_RXDATA     4'hC

`define P2C_CTRL_EN_BIT     0
`define P2C_CTRL_DIR_BIT    1
`define P2C_STAT_IDLE_BIT   0
`define P2C_STAT_RDY_BIT    1
`define P2C_STAT_PERR_BIT   2
`define P2C_STAT_FERR_BIT   3

`define P2C_RST_EN          1'b0
`define P2C_RST_DIR         1'b0
`define P2C_RST_IDLE        1'b1
`define P2C_RST_FLAG        1'b0
`define P2C_RST_BYTE        8'h00
`define P2C_LINE_IDLE       2'h3
`define P2C_LINE_HIGH       1'b1
`define P2C_LINE_LOW        1'b0
`define P2C_OE_OFF          1'b1
`define P2C_OE_ON           1'b0

`define P2C_CLK_PERIOD_NS   8
`define P2C_T4_MIN_NS       45
`define P2C_T4_MAX_NS       90
`define P2C_T5_MIN_NS       90
`define P2C_T5_MAX_NS       130
`define P2C_T12_MIN_NS      3500
`define P2C_T12_MAX_NS      7100
`define P2C_CEIL_CYC(ns)    (((ns) + `P2C_CLK_PERIOD_NS - 1) / `P2C_CLK_PERIOD_NS)

`define P2C_LAST_FALL       4'hA
`define P2C_CNT_ZERO        10'h000
`define P2C_CNT_ONE         10'h001
`define P2C_FALL_ZERO       4'h0
`define P2C_FALL_ONE        4'h1

`endif

// ===== core/p2c_sync.v
// Purpose: two-flop synchroniser for the clock and data line inputs
// Assumes: lines idle high, so reset value is high
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`include "p2c_defines.vh"

module p2c_sync (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       clk_en,
    // Lines
    input  wire [1:0] async_i,
    output reg  [1:0] sync_o
);

    reg [1:0] meta_q;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= `P2C_LINE_IDLE;
            sync_o <= `P2C_LINE_IDLE;
        end else if (clk_en) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// ===== testbench/p2c_aux_model.sv
// Purpose: behavioural keyboard or mouse on the aux clock and data wires
// Assumes: both wires open drain with pull-ups; 125 ns line clock
// Notes:   clock stands high between frames
`timescale 1ns/100ps

module p2c_aux_model (
    // Device side of the wires
    input  wire dev_clk_o,
    input  wire dev_clk_oe_n,
    input  wire dev_dat_o,
    input  wire dev_dat_oe_n,
    // Resolved wire levels
    output wire clk_line,
    output wire dat_line
);
    localparam real HALF = 62.5;
    reg      clk_rel;
    reg      dat_rel;
    realtime t_fall;
    realtime t_rise;

    assign clk_line = (dev_clk_oe_n | dev_clk_o) & clk_rel;
    assign dat_line = (dev_dat_oe_n | dev_dat_o) & dat_rel;

    initial begin
        clk_rel = 1'h1;
        dat_rel = 1'h1;
        t_fall = 0;
        t_rise = 0;
    end

    // Frame towards the device; bad flips the parity
    task send(input [7:0] b, input bad);
        reg [10:0] f;
        integer    i;
        f = {1'h1, ~^b ^ bad, b, 1'h0};
        // A held-low clock means inhibit: wait it out
        wait (clk_line === 1'h1);
        for (i = 0; i < 11; i = i + 1) begin
            dat_rel = f[i];
            #HALF clk_rel = 1'h0;
            t_fall = $realtime;
            #HALF clk_rel = 1'h1;
        end
        dat_rel = 1'h1;
    endtask

    // Frame from the device; ack driven in the eleventh clock
    task recv(output [10:0] s);
        integer i;
        wait (clk_line === 1'h1 && dat_line === 1'h0);
        #2000;
        s[0] = dat_line;
        for (i = 1; i < 12; i = i + 1) begin
            clk_rel = 1'h0;
            if (i == 11)
                dat_rel = 1'h0;
            #HALF clk_rel = 1'h1;
            t_rise = $realtime;
            #HALF;
            if (i < 11)
                s[i] = dat_line;
        end
        dat_rel = 1'h1;
    endtask
endmodule

// ===== testbench/p2c_channel_bench.sv
// Purpose: self-checking bench for the aux channel controller
// Assumes: clock enable tied high; line timing scaled to a 125 ns clock
// Notes:   st packs idle, ready, clock oe_n and data oe_n
`timescale 1ns/100ps
`include "p2c_defines.vh"

module p2c_channel_bench;
    reg         core_clk;
    reg         rst_n;
    reg  [3:0]  reg_addr;
    reg  [7:0]  reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [7:0]  reg_rdata;
    wire        clk_line, dat_line, clk_o, clk_oe_n, dat_o, dat_oe_n;
    wire        tx_idle_irq, rx_ready_irq;
    wire [3:0]  st = {tx_idle_irq, rx_ready_irq, clk_oe_n, dat_oe_n};
    integer     n_errors, compares, i;
    realtime    t0;

    p2c_channel i_p2c_channel (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(1'h1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .aux_clock_line_i(clk_line), .aux_clock_line_o(clk_o),
        .aux_clock_line_oe_n(clk_oe_n), .aux_data_line_i(dat_line),
        .aux_data_line_o(dat_o), .aux_data_line_oe_n(dat_oe_n),
        .tx_idle_irq(tx_idle_irq), .rx_ready_irq(rx_ready_irq));

    p2c_aux_model i_p2c_aux_model (.dev_clk_o(clk_o),
        .dev_clk_oe_n(clk_oe_n), .dev_dat_o(dat_o),
        .dev_dat_oe_n(dat_oe_n), .clk_line(clk_line),
        .dat_line(dat_line));

    task chk(input string nm, input [15:0] e, input [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input [3:0] a, input [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    task rd(input [3:0] a, input [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk("read data", {8'h00, e}, {8'h00, reg_rdata});
    endtask

    task t_reset;
        chk("lines", 16'h9, 16'(st));
        rd(`P2C_ADDR_STATUS, 8'h01);
        rd(`P2C_ADDR_CTRL, 8'h00);
        rd(4'h2, 8'h00);
        $display("test reset done");
    endtask

    task t_enable;
        wr(`P2C_ADDR_CTRL, 8'h01);
        repeat (124) @(posedge core_clk);
        #1 chk("lines", 16'hB, 16'(st));
        $display("test enable done");
    endtask

    task t_rx(input [7:0] b, input bad);
        i_p2c_aux_model.send(b, bad);
        i = 0;
        while (rx_ready_irq !== 1'h1 && i < 200) begin
            @(posedge core_clk);
            #1 i = i + 1;
        end
        t0 = $realtime - i_p2c_aux_model.t_fall;
        chk("ready time", 16'h1, 16'(t0 <= 1600));
        chk("lines", 16'hD, 16'(st));
        rd(`P2C_ADDR_STATUS, {5'h00, bad, 2'h3});
        rd(`P2C_ADDR_RXDATA, b);
        repeat (60) @(posedge core_clk);
        #1 chk("lines", 16'hB, 16'(st));
        $display("test receive %h done", b);
    endtask

    task t_tx(input [7:0] b);
        reg [10:0] s;
        wr(`P2C_ADDR_CTRL, 8'h03);
        repeat (3) @(posedge core_clk);
        #1 chk("lines", 16'h9, 16'(st));
        wr(`P2C_ADDR_TXDATA, b);
        i_p2c_aux_model.recv(s);
        chk("frame", {5'h00, 1'h1, ~^b, b, 1'h0}, {5'h00, s});
        i = 0;
        while (tx_idle_irq !== 1'h1 && i < 2000) begin
            @(posedge core_clk);
            #1 i = i + 1;
        end
        t0 = $realtime - i_p2c_aux_model.t_rise;
        chk("end time", 16'h1, 16'(t0 >= 3500 && t0 <= 7100));
        chk("lines", 16'hB, 16'(st));
        rd(`P2C_ADDR_CTRL, 8'h01);
        $display("test transmit %h done", b);
    endtask

    // A frame start must be refused while the channel is off
    task t_off;
        wr(`P2C_ADDR_CTRL, 8'h00);
        wr(`P2C_ADDR_TXDATA, 8'h55);
        repeat (20) @(posedge core_clk);
        #1 chk("lines", 16'h9, 16'(st));
        rd(`P2C_ADDR_STATUS, 8'h01);
        $display("test disable done");
    endtask

    task summarize;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end

    // Whole run is some 20 us; this leaves ample margin
    initial begin
        #200000;
        n_errors = n_errors + 1;
        summarize;
    end

    initial begin
        rst_n = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        n_errors = 0;
        compares = 0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        #1 t_reset;
        t_enable;
        t_rx(8'hA5, 1'h0);
        t_rx(8'h3C, 1'h1);
        t_tx(8'h00);
        t_tx(8'h5B);
        t_off;
        summarize;
    end
endmodule

bind p2c_channel p2c_channel_props i_props (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd),
    .aux_clock_line_oe_n(aux_clock_line_oe_n),
    .aux_data_line_oe_n(aux_data_line_oe_n),
    .tx_idle_irq(tx_idle_irq), .rx_ready_irq(rx_ready_irq));

// ===== testbench/p2c_channel_properties.sv
// Purpose: port timing checks for the aux channel controller
// Assumes: only the top module ports are visible
// Notes:   control bits are shadowed from register writes
`timescale 1ns/100ps
`include "p2c_defines.vh"

module p2c_channel_props (
    // Clock and reset
    input wire       core_clk,
    input wire       rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    // Lines and flags
    input wire       aux_clock_line_oe_n,
    input wire       aux_data_line_oe_n,
    input wire       tx_idle_irq,
    input wire       rx_ready_irq
);
    reg  [1:0] ctl_q;
    wire       tx_go;
    wire       rx_rd;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    assign rx_rd = reg_rd && reg_addr == `P2C_ADDR_RXDATA;
    // Only a write in the inhibited waiting state launches a frame
    assign tx_go = reg_wr && reg_addr == `P2C_ADDR_TXDATA && ctl_q == 2'h3
        && tx_idle_irq && !aux_clock_line_oe_n && aux_data_line_oe_n;

    // Hardware drops direction when a transfer ends
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            ctl_q <= 2'h0;
        else if (reg_wr && reg_addr == `P2C_ADDR_CTRL)
            ctl_q <= reg_wdata[1:0];
        else if ($rose(tx_idle_irq))
            ctl_q[1] <= 1'h0;
    end

    a_rx_float: assert property (
        $rose(ctl_q[0]) && !ctl_q[1] |->
        ##[1:124] (aux_clock_line_oe_n && aux_data_line_oe_n))
        else $error("lines not floated after enable");
    a_tx_inhibit: assert property (
        $rose(ctl_q[1]) && ctl_q[0] |-> ##[1:2] !aux_clock_line_oe_n)
        else $error("clock not pulled low for transmit");
    a_start_bit: assert property (
        tx_go |-> aux_data_line_oe_n [*7] ##[1:6] !aux_data_line_oe_n)
        else $error("start bit outside its window");
    a_clock_handover: assert property (
        tx_go |-> !aux_clock_line_oe_n [*8] ##1 !aux_clock_line_oe_n [*5]
        ##[1:5] aux_clock_line_oe_n)
        else $error("clock release outside its window");
    a_idle_clear: assert property (
        $rose(aux_clock_line_oe_n) && ctl_q == 2'h3 |-> !tx_idle_irq)
        else $error("idle flag kept at launch");
    a_tx_end_release: assert property (
        $rose(tx_idle_irq) |-> aux_data_line_oe_n [*8])
        else $error("data held after transmit end");
    a_rx_ready_hold: assert property (
        $rose(rx_ready_irq) |-> !aux_clock_line_oe_n)
        else $error("clock not held at frame end");
    a_rx_read_clear: assert property (
        rx_rd |-> ##[1:62] !rx_ready_irq)
        else $error("ready flag not cleared by read");
    a_held_until_read: assert property (
        rx_ready_irq && !rx_rd |=> !aux_clock_line_oe_n)
        else $error("clock released before read");
    a_read_release: assert property (
        rx_rd && rx_ready_irq && ctl_q == 2'h1 |-> ##[1:2] aux_clock_line_oe_n)
        else $error("clock not released by read");
    a_disabled_lines: assert property (
        !ctl_q[0] |=> !aux_clock_line_oe_n && aux_data_line_oe_n)
        else $error("wrong line state while disabled");
endmodule
